// File: common/sbi2c_consts.svh
// Offsets, field positions, reset values and timing counts for the
// single-bit two-wire interface. Definitions only; included by bare name.
`ifndef SBI2C_CONSTS_SVH
`define SBI2C_CONSTS_SVH

// ------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define SBI_IDX_CTRL     10'h0d8
`define SBI_IDX_DATA     10'h0d9
`define SBI_IDX_CFG      10'h0da
`define SBI_IDX_IRQ      10'h0db

// ------------------------------------------------------------
// Control register bits (write commands / read flags)
// ------------------------------------------------------------
`define SBI_B_RXBIT      7
`define SBI_B_ATN        6
`define SBI_B_BIT_READY_FLAG       5
`define SBI_B_ARL        4
`define SBI_B_STR        3
`define SBI_B_STP        2
`define SBI_B_MST        1
`define SBI_B_CXA        7
`define SBI_B_IDLE       6
`define SBI_B_CDR        5
`define SBI_B_CLEAR_ARBITRATION_LOST       4
`define SBI_B_CLEAR_START_SEEN       3
`define SBI_B_CLEAR_STOP_SEEN       2
`define SBI_B_ISSUE_REPEATED_START       1
`define SBI_B_ISSUE_STOP       0
`define SBI_CTRL_RESET   8'h81

// ------------------------------------------------------------
// Config and interrupt register bits
// ------------------------------------------------------------
`define SBI_B_SLVEN      7
`define SBI_B_MSTRQ      6
`define SBI_B_WATCH_TIMER_RUN      4
`define SBI_B_CT1        1
`define SBI_B_CT0        0
`define SBI_B_GIE        7
`define SBI_B_BIE        0
`define SBI_B_TIE        1
`define SBI_B_TPH        3
`define SBI_B_TPL        2

// ------------------------------------------------------------
// Timing: nominal span and derived cycles at 20 MHz
// ------------------------------------------------------------
`define SBI_CLK_NS       50
`define SBI_MIN_SPAN_NS  4700000
`define SBI_MIN_SPAN_CYC ((`SBI_MIN_SPAN_NS + `SBI_CLK_NS - 1) / `SBI_CLK_NS)
`define SBI_MIN_BIT      3
`define SBI_TMR_MAX      10'h3ff

`endif

// File: common/sbi2c_pkg.sv
// Types for the single-bit two-wire interface.
// Assumes the constants header is included wherever numbers are needed.
package sbi2c_pkg;

  // ------------------------------------------------------------
  // Master sequencer phases, one-hot
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    SBI_IDLE  = 8'h01,
    SBI_START = 8'h02,
    SBI_LOW   = 8'h04,
    SBI_HIGH  = 8'h08,
    SBI_STOP1 = 8'h10,
    SBI_STOP2 = 8'h20,
    SBI_RS1   = 8'h40,
    SBI_RS2   = 8'h80
  } sbi_phase_t;

  // ------------------------------------------------------------
  // Whole block state carried as one record
  // ------------------------------------------------------------
  typedef struct packed {
    sbi_phase_t  phase;
    logic [9:0]  tmr;
    logic        scl_q, sda_q;
    logic        rx_bit, bit_ready, arb_lost, start_seen, stop_seen;
    logic        xmit_active, tx_bit, is_master, idle, in_frame;
    logic        stop_req, rs_req, scl_low, sda_low, slv_hold;
    logic        slave_en, master_req, watch_timer_run;
    logic [1:0]  ct;
    logic        gie, bie, tie, tp_hi, tp_lo;
    logic        ack;
    logic [7:0]  dat;
    logic        bus_irq, tmr_irq;
  } sbi_state_t;

endpackage : sbi2c_pkg

// File: design/sbi2c_top.sv
// Single-bit two-wire serial interface with bus timer, Wishbone slave.
// Assumes scl_i/sda_i are already synchronous to clk_i and that the
// pads are open drain, resolved outside from the _oe_n outputs.
`timescale 1ns/1ps
`include "sbi2c_consts.svh"

// Summary of operation
// R01 - Low timer bits enforce five minimum spans
// R02 - Timer on CPU clock, four preloads selectable
// R03 - Ten bits time SCL; SCL edges preload
// R04 - Timer stopped between frames
// R05 - Carry after 1020 to 1023 cycles
// R06 - Carry resets interface, releases SCL, interrupts
// R07 - Full run and timeout need run bit
// R08 - Timer interrupt enable and priority bits
// R09 - Attention raises bus interrupt when enabled
// R10 - SDA captured each SCL rise, readable
// R11 - Data read clears ready; control read not
// R12 - Attention is OR of four flags
// R13 - Ready set each SCL rise unless idle
// R14 - Ready cleared by command or data access
// R15 - SCL held low until ready cleared
// R16 - Low span kept even on fast software
// R17 - Idle command makes slave ignore bus
// R18 - Software reads seven bits, then control
// R19 - Software uses interrupt only for idle waits
// R20 - Preload gives minimum and timeout counts
// R21 - Data write sets bit, clears ready, transmits
// R22 - Other flags keep SCL low
// R23 - Without run bit only low bits count
// R24 - Command bits act on one, ignore zero
// R25 - Bit 1 shows master, bit 0 undefined
module sbi2c_top
  import sbi2c_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  output logic             bus_irq_o,
  output logic             tmr_irq_o,
  output logic [1:0]       tmr_prio_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Preload per prescale field; carry at 1024 gives the timeout
  function automatic logic [9:0] sbi_preload(input logic [1:0] ct);
    unique case (ct)
      2'b10:   sbi_preload = 10'h001;   // R20
      2'b01:   sbi_preload = 10'h002;   // R20
      2'b00:   sbi_preload = 10'h003;   // R20
      default: sbi_preload = 10'h004;   // R20
    endcase
  endfunction : sbi_preload

  // Minimum span elapsed once the low three bits have carried
  function automatic logic sbi_min_done(input logic [9:0] t);
    sbi_min_done = |t[9:`SBI_MIN_BIT];
  endfunction : sbi_min_done

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  sbi_state_t st;        // Registered state
  sbi_state_t next_st;   // Next state

  logic [9:0] reg_idx;   // Word index of the access
  logic       req;       // New bus access this cycle
  logic       wr_ctrl;   // Control register write
  logic       wr_data;   // Data register write
  logic       rd_data;   // Data register read
  logic       enabled;   // Interface enabled
  logic       scl_rise;  // SCL edges and conditions
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       flags_hold; // Flags other than ready
  logic       attention;
  logic       min_done;
  logic       carry;     // Hung-bus timeout
  logic       act_slave; // Non-idle slave participation
  logic [7:0] w;         // Written byte

  // ------------------------------------------------------------
  // Decode and bus events
  // ------------------------------------------------------------
  always_comb begin
    reg_idx    = adr_i[11:2];
    req        = cyc_i & stb_i & ~st.ack;
    w          = sel_i[0] ? dat_i[7:0] : 8'h00;
    wr_ctrl    = req & we_i & (reg_idx == `SBI_IDX_CTRL);
    wr_data    = req & we_i & sel_i[0] & (reg_idx == `SBI_IDX_DATA);
    rd_data    = req & ~we_i & (reg_idx == `SBI_IDX_DATA);
    enabled    = st.slave_en | st.master_req | st.is_master;
    scl_rise   = enabled & scl_i & ~st.scl_q;
    scl_fall   = enabled & ~scl_i & st.scl_q;
    start_det  = enabled & scl_i & st.scl_q & ~sda_i & st.sda_q;
    stop_det   = enabled & scl_i & st.scl_q & sda_i & ~st.sda_q;
    flags_hold = st.arb_lost | st.start_seen | st.stop_seen;
    attention  = st.bit_ready | flags_hold;                    // R12
    min_done   = sbi_min_done(st.tmr);
    act_slave  = ~st.idle | st.is_master;
    // Carry only in frame with the run bit set
    carry      = enabled & st.watch_timer_run & st.in_frame & (st.tmr == `SBI_TMR_MAX); // R05 R07
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.ack   = req;                 // One wait state, any address
    next_st.scl_q = scl_i;
    next_st.sda_q = sda_i;
    next_st.tmr_irq = 1'b0;

    // Read data, unmapped indexes read zero
    if (req && !we_i) begin
      unique case (reg_idx)
        `SBI_IDX_CTRL: next_st.dat = {st.rx_bit, attention, st.bit_ready,
                                      st.arb_lost, st.start_seen,
                                      st.stop_seen, st.is_master, 1'b1}; // R10 R25
        `SBI_IDX_DATA: next_st.dat = {st.rx_bit, 7'h00};          // R10
        `SBI_IDX_CFG:  next_st.dat = {st.slave_en, st.master_req, 1'b0,
                                      st.watch_timer_run, 2'b00, st.ct};
        `SBI_IDX_IRQ:  next_st.dat = {st.gie, 3'b000, st.tp_hi, st.tp_lo,
                                      st.tie, st.bie};
        default:       next_st.dat = 8'h00;
      endcase
    end

    // Config and interrupt enable writes
    if (req && we_i && sel_i[0] && reg_idx == `SBI_IDX_CFG) begin
      next_st.slave_en   = w[`SBI_B_SLVEN];
      next_st.master_req = w[`SBI_B_MSTRQ];
      next_st.watch_timer_run      = w[`SBI_B_WATCH_TIMER_RUN];                      // R07
      next_st.ct         = {w[`SBI_B_CT1], w[`SBI_B_CT0]};       // R02
    end
    if (req && we_i && sel_i[0] && reg_idx == `SBI_IDX_IRQ) begin
      next_st.gie   = w[`SBI_B_GIE];
      next_st.bie   = w[`SBI_B_BIE];
      next_st.tie   = w[`SBI_B_TIE];                              // R08
      next_st.tp_hi = w[`SBI_B_TPH];                              // R08
      next_st.tp_lo = w[`SBI_B_TPL];                              // R08
    end

    // Clears first; hardware sets below win in the same cycle
    if (wr_ctrl) begin
      if (w[`SBI_B_CXA])  next_st.xmit_active = 1'b0;             // R24
      if (w[`SBI_B_CDR])  next_st.bit_ready   = 1'b0;             // R14
      if (w[`SBI_B_CLEAR_ARBITRATION_LOST]) next_st.arb_lost    = 1'b0;             // R24
      if (w[`SBI_B_CLEAR_START_SEEN]) next_st.start_seen  = 1'b0;             // R24
      if (w[`SBI_B_CLEAR_STOP_SEEN]) next_st.stop_seen   = 1'b0;             // R24
      if (w[`SBI_B_ISSUE_REPEATED_START] && st.is_master) next_st.rs_req   = 1'b1; // R24
      if (w[`SBI_B_ISSUE_STOP] && st.is_master) next_st.stop_req = 1'b1; // R24
      if (w[`SBI_B_IDLE] && !st.is_master) next_st.idle    = 1'b1; // R17
    end
    // Data access frees the bit; a read also ends transmission
    if (rd_data) begin
      next_st.bit_ready   = 1'b0;                                 // R11 R14
      next_st.xmit_active = 1'b0;
    end
    if (wr_data) begin
      next_st.tx_bit      = w[7];                                 // R21
      next_st.bit_ready   = 1'b0;                                 // R14 R21
      next_st.xmit_active = 1'b1;                                 // R21
    end

    // Bus timer: preload on SCL change and on conditions
    if (!enabled) begin
      next_st.tmr = 10'h000;
    end else if (scl_rise || scl_fall || start_det || stop_det) begin
      next_st.tmr = sbi_preload(st.ct);                           // R02 R03
    end else if (st.watch_timer_run && st.in_frame) begin
      next_st.tmr = st.tmr + 10'h001;                             // R03
    end else if (!min_done) begin
      // Low bits only: saturate once the minimum span is out
      next_st.tmr = st.tmr + 10'h001;                             // R01 R04 R23
    end

    // Bit capture and ready flag
    if (scl_rise) begin
      next_st.rx_bit = sda_i;                                     // R10
      if (act_slave) next_st.bit_ready = 1'b1;                    // R13
      // Lost arbitration: released a one, bus shows zero
      if (st.xmit_active && st.tx_bit && !sda_i) begin
        next_st.arb_lost    = 1'b1;
        next_st.xmit_active = 1'b0;
        if (st.is_master) begin
          next_st.is_master = 1'b0;
          next_st.phase     = SBI_IDLE;
          next_st.scl_low   = 1'b0;
        end
      end
    end
    // Frame tracking and condition flags
    if (start_det) begin
      next_st.in_frame = 1'b1;
      if (act_slave || st.idle) next_st.start_seen = 1'b1;
      next_st.idle = 1'b0;              // Start wakes an idle slave
    end
    if (stop_det) begin
      next_st.in_frame = 1'b0;                                    // R04
      if (act_slave) next_st.stop_seen = 1'b1;
      next_st.is_master = 1'b0;
    end

    // Slave stretch: hold low after a ready event until served
    if (!st.is_master) begin
      if (scl_fall && act_slave && attention) begin
        next_st.slv_hold = 1'b1;                                  // R15
      end else if (st.slv_hold && !attention && min_done) begin
        next_st.slv_hold = 1'b0;                                  // R16 R22
      end
      // Update the data bit only while SCL is low; it holds while SCL is high
      if (!scl_i) next_st.sda_low = act_slave & st.xmit_active & ~st.tx_bit;
    end

    // Master sequencer
    unique case (st.phase)
      SBI_IDLE: begin
        if (st.master_req && !st.in_frame && min_done && scl_i && sda_i) begin
          next_st.sda_low = 1'b1;                                 // R01
          next_st.phase   = SBI_START;
        end
      end
      SBI_START: begin
        if (min_done) begin                                       // R01
          next_st.scl_low   = 1'b1;
          next_st.is_master = 1'b1;
          next_st.phase     = SBI_LOW;
        end
      end
      SBI_LOW: begin
        next_st.sda_low = st.xmit_active & ~st.tx_bit;
        if (min_done && !st.bit_ready && st.stop_req) begin
          next_st.sda_low  = 1'b1;
          next_st.stop_req = 1'b0;
          next_st.phase    = SBI_STOP1;
        end else if (min_done && !st.bit_ready && st.rs_req) begin
          next_st.sda_low = 1'b0;
          next_st.rs_req  = 1'b0;
          next_st.phase   = SBI_RS1;
        end else if (min_done && !attention) begin                // R15 R16 R22
          next_st.scl_low = 1'b0;
          next_st.phase   = SBI_HIGH;
        end
      end
      SBI_HIGH: begin
        // Wait out slave stretching, then the high span
        if (st.scl_q && scl_i && min_done) begin                  // R01
          next_st.scl_low = 1'b1;
          next_st.phase   = SBI_LOW;
        end
      end
      SBI_STOP1: begin
        if (min_done) begin
          next_st.scl_low = 1'b0;
          next_st.phase   = SBI_STOP2;
        end
      end
      SBI_STOP2: begin
        if (st.scl_q && scl_i && min_done) begin                  // R01
          next_st.sda_low = 1'b0;
          next_st.phase   = SBI_IDLE;
        end
      end
      SBI_RS1: begin
        if (min_done) begin
          next_st.scl_low = 1'b0;
          next_st.phase   = SBI_RS2;
        end
      end
      SBI_RS2: begin
        if (st.scl_q && scl_i && min_done) begin
          next_st.sda_low = 1'b1;
          next_st.phase   = SBI_START;
        end
      end
      default: next_st.phase = SBI_IDLE;
    endcase

    // Timeout: reset the interface and free the wires
    if (carry) begin
      next_st.phase       = SBI_IDLE;                             // R06
      next_st.scl_low     = 1'b0;                                 // R06
      next_st.sda_low     = 1'b0;
      next_st.slv_hold    = 1'b0;
      next_st.is_master   = 1'b0;
      next_st.xmit_active = 1'b0;
      next_st.bit_ready   = 1'b0;
      next_st.in_frame    = 1'b0;
      next_st.stop_req    = 1'b0;
      next_st.rs_req      = 1'b0;
      next_st.tmr         = 10'h000;
      next_st.tmr_irq     = st.gie & st.tie;                      // R06 R08
    end

    // Interrupt request levels
    next_st.bus_irq = st.gie & st.bie &
                      (next_st.bit_ready | next_st.arb_lost |
                       next_st.start_seen | next_st.stop_seen);   // R09
  end

  // ------------------------------------------------------------
  // Registers; clock enable freezes everything
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st        <= '0;
      st.phase  <= SBI_IDLE;
      st.rx_bit <= 1'(`SBI_CTRL_RESET >> `SBI_B_RXBIT);
      st.scl_q  <= 1'b1;
      st.sda_q  <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs from flip-flops, scl_oe_n_o through one OR gate; scl_o and sda_o tied low
  // ------------------------------------------------------------
  always_comb begin
    dat_o      = {24'h000000, st.dat};
    ack_o      = st.ack;
    scl_o      = 1'b0;                           // Open drain: low or off
    scl_oe_n_o = ~(st.scl_low | st.slv_hold);    // Low while pulling
    sda_o      = 1'b0;
    sda_oe_n_o = ~st.sda_low;
    bus_irq_o  = st.bus_irq;
    tmr_irq_o  = st.tmr_irq;
    tmr_prio_o = {st.tp_hi, st.tp_lo};
  end

endmodule : sbi2c_top

// File: sim/sbi2c_properties.sv
// Checker for the single-bit two-wire block; sees the top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "sbi2c_consts.svh"
module sbi2c_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_n_o,
  input wire logic        sda_o,
  input wire logic        sda_oe_n_o,
  input wire logic        bus_irq_o,
  input wire logic        tmr_irq_o,
  input wire logic [1:0]  tmr_prio_o
);
  // --------
  // Helper logic
  // --------
  logic [10:0] quiet;         // Cycles since SCL moved
  logic [10:0] next_quiet;
  logic [3:0]  low_run;       // Cycles SCL has stayed low
  logic [3:0]  next_low_run;
  logic        scl_d;         // SCL one cycle back
  logic        take;          // Request accepted at this edge
  logic        rd_ack;        // Read answer on the bus
  logic [9:0]  idx;           // Register index

  // Counters saturate, so a long stall never wraps into a false pass
  always_comb begin
    idx = adr_i[11:2];
    take = cyc_i && stb_i && ce_i && !ack_o;
    rd_ack = ack_o && !we_i;
    next_quiet = (scl_i != scl_d) ? 11'h0 : quiet + {10'h0, quiet != 11'h7ff};
    next_low_run = scl_i ? 4'h0 : low_run + {3'h0, low_run != 4'hf};
  end

  // Register the helpers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quiet   <= 11'h0;
      low_run <= 4'h0;
      scl_d   <= 1'b1;
    end else begin
      quiet   <= next_quiet;
      low_run <= next_low_run;
      scl_d   <= scl_i;
    end
  end

  // --------
  // Properties
  // --------
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_follow_a: assert property (take |=> ack_o) else $error("request not answered");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held over");
  open_drain_a: assert property (!scl_o && !sda_o) else $error("wire driven high");
  tmr_pulse_a: assert property (tmr_irq_o |=> !tmr_irq_o)
    else $error("timeout irq held");
  tmo_release_a: assert property (tmr_irq_o |-> ##[0:1] (scl_oe_n_o && sda_oe_n_o))
    else $error("wires kept after timeout");
  tmo_quiet_a: assert property (tmr_irq_o |-> quiet >= 11'd1019)
    else $error("timeout too early");
  low_span_a: assert property ($rose(scl_oe_n_o) |-> low_run >= 4'd3)
    else $error("clock low span short");
  prio_write_a: assert property (ack_o && we_i && sel_i[0] && idx == `SBI_IDX_IRQ
    |=> tmr_prio_o == $past(dat_i[3:2])) else $error("priority not taken");
  hole_read_a: assert property (rd_ack && idx > `SBI_IDX_IRQ |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  data_read_a: assert property (rd_ack && idx == `SBI_IDX_DATA |->
    dat_o[31:8] == 24'h0 && dat_o[6:0] == 7'h0) else $error("data read low bits");
  atn_or_a: assert property (rd_ack && idx == `SBI_IDX_CTRL |->
    dat_o[6] == |dat_o[5:2]) else $error("attention mismatch");
endmodule : sbi2c_properties

bind sbi2c_top sbi2c_properties chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .bus_irq_o(bus_irq_o), .tmr_irq_o(tmr_irq_o),
  .tmr_prio_o(tmr_prio_o)
);

// File: sim/sbi2c_far.sv
// Far-side two-wire master model, open drain on SCL and SDA.
// Assumes pull-ups on both wires; a 1 on an output releases it.
`timescale 1ns/1ps
module sbi2c_far (
  input  wire logic clk_i,
  input  wire logic scl_i,
  output logic      scl_o,
  output logic      sda_o
);
  localparam int H = 12;  // Half bit, above the longest minimum span

  // Both wires released at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wt(input int k);
    repeat (k) @(posedge clk_i);
  endtask : wt

  // Release SCL and honour stretching, bounded so a stuck wire cannot hang
  task automatic rise;
    int k;
    k = 0;
    scl_o <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (scl_i !== 1'b1 && k < 400);
    wt(H);
  endtask : rise

  // SDA falls while SCL high, then SCL falls
  task automatic start;
    wt(H);
    sda_o <= 1'b0;
    wt(H);
    scl_o <= 1'b0;
    wt(H);
  endtask : start

  // Data changes only while SCL is low; ends with SCL high
  task automatic put_bit(input logic v);
    scl_o <= 1'b0;
    wt(H);
    sda_o <= v;
    wt(H);
    rise();
  endtask : put_bit

  // One SCL fall, then release; the device may keep the wire low
  task automatic pulse_low;
    scl_o <= 1'b0;
    wt(H);
    scl_o <= 1'b1;
    wt(2);
  endtask : pulse_low

  // SDA rises while SCL high
  task automatic stop;
    scl_o <= 1'b0;
    wt(H);
    sda_o <= 1'b0;
    wt(H);
    rise();
    sda_o <= 1'b1;
    wt(H);
  endtask : stop
endmodule : sbi2c_far

// File: sim/sbi2c_bench.sv
// Self-checking bench for the single-bit two-wire block.
// Assumes the far-side model and the bound checker are compiled before.
`timescale 1ns/1ps
`include "sbi2c_consts.svh"
module sbi2c_bench;
  // --------
  // Stimulus, wires and model state
  // --------
  logic        clk_i = 1'b0;                // 20 MHz clock
  logic        rst_i = 1'b1;                // Synchronous reset
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h0;                 // Byte address
  logic [3:0]  sel = 4'h0;                  // Byte lanes
  logic [31:0] dat_w = 32'h0;               // Write data
  logic [31:0] dat_o;                       // Read data
  logic        ack_o, scl_oe_n, sda_oe_n, bus_irq, tmr_irq;
  logic [1:0]  prio;                        // Timer irq priority
  logic        far_scl, far_sda;            // Far side, 1 releases
  wire         scl_w = far_scl & scl_oe_n;  // Pulled-up wires
  wire         sda_w = far_sda & sda_oe_n;
  logic [7:0]  q;                           // Last byte read
  logic        scl_p = 1'b1;                // SCL seen last cycle
  int          error_cnt = 0, tests_run = 0, cyc_n = 0, last_chg = 0, n;
  int          bits[$];                     // Model: bits sent
  int          tmo[4] = '{1021, 1022, 1023, 1020};  // Timeout per prescale

  always #25 clk_i = ~clk_i;

  sbi2c_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o),
    .scl_i(scl_w), .sda_i(sda_w), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_o(),
    .sda_oe_n_o(sda_oe_n), .bus_irq_o(bus_irq), .tmr_irq_o(tmr_irq), .tmr_prio_o(prio));
  sbi2c_far far (.clk_i(clk_i), .scl_i(scl_w), .scl_o(far_scl), .sda_o(far_sda));

  // Cycle count and the cycle of the last SCL change
  always @(posedge clk_i) begin
    cyc_n++;
    if (scl_w !== scl_p) last_chg = cyc_n;
    scl_p = scl_w;
  end

  // --------
  // Tasks
  // --------
  task automatic wt(input int k);
    repeat (k) @(posedge clk_i);
  endtask : wt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled, so no latency assumed
  task automatic wb(input logic [9:0] idx, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, idx, 2'b00, 4'h1, 24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    {cyc, stb, we} <= 3'b000;
    chk(k < 20, 1);
  endtask : wb

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Watchdog, well beyond the roughly 7000 cycles the tests take
  initial begin
    wt(30000);
    error_cnt++;
    test_done();
  end

  // --------
  // Main sequence
  // --------
  initial begin
    void'($urandom(32'h802740b2));
    wt(4);
    rst_i <= 1'b0;
    wb(`SBI_IDX_CTRL, 0, 8'h0);
    chk(q, 8'h81);
    chk({scl_oe_n, sda_oe_n, bus_irq, tmr_irq}, 4'hc);
    wb(10'h0e0, 0, 8'h0);
    chk(q, 8'h0);
    $display("test reset done");
    // Slave receive: random bits, stretching, two ways to clear ready
    for (int i = 0; i < 6; i++) bits.push_back($urandom % 2);
    wb(`SBI_IDX_CFG, 1, 8'h80);
    wb(`SBI_IDX_IRQ, 1, 8'h81);
    far.start();
    chk(bus_irq, 1);
    // Start flag alone keeps SCL low, so the first bit waits for its clear
    fork
      far.put_bit(bits[0][0]);
      begin
        wt(40);
        chk(scl_w, 0);
        wb(`SBI_IDX_CTRL, 1, 8'h08);
      end
    join
    for (int i = 0; i < 6; i++) begin
      wb(`SBI_IDX_CTRL, 0, 8'h0);
      chk(q, {bits[i][0], 7'h61});
      fork
        if (i < 5) far.put_bit(bits[i + 1][0]);
        begin
          wt(40);
          chk(scl_w, i == 5);
          if (i % 2) begin
            wb(`SBI_IDX_CTRL, 1, 8'h20);
          end else begin
            wb(`SBI_IDX_DATA, 0, 8'h0);
            chk(q, {bits[i][0], 7'h0});
          end
          // Last bit: no further rise can set ready again
          if (i == 5) begin
            wb(`SBI_IDX_CTRL, 0, 8'h0);
            chk(q[5], 0);
            wt(20);
            chk(scl_w, 1);
            wb(`SBI_IDX_CTRL, 1, 8'h08);
          end
        end
      join
      chk(scl_w, 1);
    end
    far.stop();
    wb(`SBI_IDX_CTRL, 0, 8'h0);
    chk(q[2], 1);
    wb(`SBI_IDX_CTRL, 1, 8'h3c);
    wt(2);
    chk(bus_irq, 0);
    wb(`SBI_IDX_CTRL, 1, 8'h40);
    far.put_bit(1'b1);
    wb(`SBI_IDX_CTRL, 0, 8'h0);
    chk(q[5], 0);
    $display("test receive done");
    // Hung frame per prescale, then once with the run bit clear
    for (int p = 0; p < 5; p++) begin
      wb(`SBI_IDX_CFG, 1, (p < 4) ? {6'h24, p[1:0]} : 8'h80);
      wb(`SBI_IDX_IRQ, 1, {4'h8, p[1:0], 2'b11});
      wt(1);
      chk(prio, p[1:0]);
      far.start();
      wb(`SBI_IDX_CTRL, 1, 8'h08);
      wb(`SBI_IDX_DATA, 1, 8'h00);
      far.put_bit(1'b1);
      chk(sda_oe_n, 0);
      far.pulse_low();
      n = 0;
      while (tmr_irq !== 1'b1 && n < 1200) begin
        @(posedge clk_i);
        n++;
      end
      if (p < 4) begin
        chk(cyc_n - last_chg >= tmo[p] - 1 && cyc_n - last_chg <= tmo[p] + 4, 1);
      end else begin
        chk(n, 1200);
      end
      wt(3);
      chk(scl_w, p < 4);
      wb(`SBI_IDX_DATA, 0, 8'h0);
      wt(20);
      wb(`SBI_IDX_CTRL, 1, 8'h20);
      far.stop();
      wb(`SBI_IDX_CTRL, 1, 8'h3c);
    end
    $display("test timeout done");
    test_done();
  end
endmodule : sbi2c_bench
